// *** pkg/corr_params.svh ***
// Constants of the correction datapath.
`ifndef CORR_PARAMS_SVH
`define CORR_PARAMS_SVH

// ================
// Register byte offsets on the Wishbone slave.
`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_COEF_BASE  8'h08
`define OFS_BRIDGE     8'h34
`define OFS_TEMP       8'h38
`define NUM_COEF       11

// ================
// Coefficient word indices, counted from the coefficient base.
`define CI_GAIN_B      0
`define CI_OFFSET_B    1
`define CI_GAIN_DRIFT  2
`define CI_OFFS_DRIFT  3
`define CI_GAIN_DRIFT2 4
`define CI_OFFS_DRIFT2 5
`define CI_BRIDGE_NL   6
`define CI_TEMP_REF    7
`define CI_GAIN_T      8
`define CI_OFFSET_T    9
`define CI_TEMP_NL     10

// ================
// Field positions and reset values.
`define CTRL_CURVE_BIT 0
`define STAT_SAT_BIT   0
`define STAT_BUSY_BIT  1
`define CTRL_RST       1'b0
`define COEF_RST       18'h00000

// ================
// Saturation bounds, 19-bit signed, and sequencer figures.
`define LIM_LO         19'sh60000
`define LIM_HI         19'sh1ffff
`define LIM_ZERO       19'sh00000
`define LIM_HALF       19'sh08000
`define LIM_B_S        19'sh10000
`define LIM_B_P        19'sh0ffff
`define FRAC_BITS      15
`define LAST_STEP      5'h16

`endif

// *** pkg/corr_pkg.sv ***
// Types shared by the correction datapath modules.
package corr_pkg;

  // ================
  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } seq_state_t;

  // Destination of one arithmetic step.
  typedef enum logic [3:0] {
    DST_DT, DST_K1, DST_K2, DST_Z, DST_ZT, DST_ACC, DST_M, DST_BR, DST_TP
  } dest_t;

  // One extra bit above 18 so that the magnitude of -2^17 is representable.
  typedef logic signed [18:0] opnd_t;

  // One ALU instruction: operands, saturation window and destination.
  typedef struct packed {
    logic  mul;
    opnd_t a;
    opnd_t b;
    opnd_t lo;
    opnd_t hi;
    dest_t dst;
  } alu_op_t;

  // Measurement result handed to the output interface.
  typedef struct packed {
    logic [7:0]  status;
    logic [16:0] bridge;
    logic [16:0] temp;
  } corr_result_t;

endpackage : corr_pkg

// *** rtl/corr_alu.sv ***
// Saturating add or multiply-and-shift unit used by every correction step.
`timescale 1ns/100ps
`include "corr_params.svh"

module corr_alu (
  input  corr_pkg::alu_op_t op_i,  // Operation, operands and bounds.
  output corr_pkg::opnd_t   res_o, // Bounded result.
  output logic              sat_o  // High when the result was clamped.
);
  import corr_pkg::*;

  // ================
  // Full-width arithmetic.
  logic signed [37:0] prod;  // Exact 19x19 product.
  logic signed [37:0] val;   // Unbounded result.
  logic signed [37:0] lo_x;  // Lower bound at full width.
  logic signed [37:0] hi_x;  // Upper bound at full width.

  // The product keeps every bit, so nothing is lost before bounding.
  assign prod = $signed(op_i.a) * $signed(op_i.b);

  // Select, then clamp. The shift rounds toward minus infinity.
  always_comb begin
    if (op_i.mul) begin
      val = prod >>> `FRAC_BITS;  // see RULE12
    end else begin
      val = 38'(op_i.a) + 38'(op_i.b);
    end
    lo_x  = 38'(op_i.lo);
    hi_x  = 38'(op_i.hi);
    sat_o = 1'b0;
    if (val > hi_x) begin
      res_o = op_i.hi;  // see RULE9
      sat_o = 1'b1;
    end else if (val < lo_x) begin
      res_o = op_i.lo;  // see RULE9
      sat_o = 1'b1;
    end else begin
      res_o = val[18:0];
    end
  end

endmodule : corr_alu

// *** rtl/sensor_correction_math.sv ***
// Sequenced bridge and temperature correction, Wishbone registers.
`timescale 1ns/100ps
`include "corr_params.svh"

// Behaviour
// RULE1 - Curve select 1: S-curve intermediate, saturated twice.
// RULE2 - S-curve bridge output clamped to 0..2^16.
// RULE3 - Temperature: gain, offset, always parabolic second order.
// RULE4 - Temperature done as intermediate then corrected output.
// RULE5 - Temperature intermediate: add, scale, offset, clamp.
// RULE6 - Corrected temperature clamped to 0..2^17-1.
// RULE7 - Raw temperature is signed 18-bit auto-zero reading.
// RULE8 - Temperature offset is signed 18-bit, added first.
// RULE9 - Every bound clamps and records saturation.
// RULE10 - Saturation in status bit 0; output still delivered.
// RULE11 - Gain and offset drift factors, each step saturated.
// RULE12 - Divide by 2^15 as shift of full product.
// RULE13 - Start on new reading, pulse done when ready.
module sensor_correction_math #(
  parameter int RAW_W = 18                  // Width of raw readings.
) (
  input  logic                   clk_i,     // 200 MHz system clock.
  input  logic                   rst_i,     // Synchronous reset, active high.
  input  logic                   wb_cyc_i,  // Wishbone cycle.
  input  logic                   wb_stb_i,  // Wishbone strobe.
  input  logic                   wb_we_i,   // Wishbone write enable.
  input  logic [7:0]             wb_adr_i,  // Wishbone byte address.
  input  logic [3:0]             wb_sel_i,  // Wishbone byte lanes.
  input  logic [31:0]            wb_dat_i,  // Wishbone write data.
  output logic [31:0]            wb_dat_o,  // Wishbone read data.
  output logic                   wb_ack_o,  // Wishbone acknowledge.
  input  logic                   raw_valid_i,  // New auto-zero reading pulse.
  input  logic [RAW_W-1:0]       raw_bridge_i, // Raw bridge reading, signed.
  input  logic [RAW_W-1:0]       raw_temp_i,   // Raw temperature, signed.
  output logic                   done_o,    // Result ready pulse.
  output corr_pkg::corr_result_t result_o   // Corrected outputs and status.
);
  import corr_pkg::*;

  // ================
  // Parameter check.
  // The arithmetic bounds are fixed to 18-bit signed operands.
  if (RAW_W != 18) begin : g_bad_width
    $error("RAW_W must be 18");
  end

  // ================
  // Helper functions.

  // Sign-extend an 18-bit value into an operand.
  function automatic opnd_t sx(input logic [17:0] v);
    sx = {v[17], v};
  endfunction : sx

  // Build one ALU instruction.
  function automatic alu_op_t mk(input logic mul, input opnd_t a, input opnd_t b,
                                 input opnd_t lo, input opnd_t hi, input dest_t dst);
    mk = '{mul, a, b, lo, hi, dst};
  endfunction : mk

  // Byte-lane merge of a write into an old word.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        merge[8*i +: 8] = n[8*i +: 8];
      end
    end
  endfunction : merge

  // True when an aligned address falls on a coefficient word.
  function automatic logic coef_hit(input logic [7:0] a);
    coef_hit = (a >= `OFS_COEF_BASE) && (a < `OFS_BRIDGE);
  endfunction : coef_hit

  // Coefficient index of an aligned address.
  function automatic logic [3:0] coef_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - `OFS_COEF_BASE;
    coef_idx = d[5:2];
  endfunction : coef_idx

  // ================
  // Declarations.
  logic [7:0]   aw;                        // Word-aligned bus address.
  logic         wr_en;                     // Write accepted this cycle.
  logic         ack_reg;                   // Registered acknowledge.
  logic [31:0]  rd_next;                   // Read data to be registered.
  logic [31:0]  rd_reg;                    // Registered read data.
  logic         ctrl_reg;                  // Curve shape select.
  logic [31:0]  ctrl_merged;               // Control word after a write.
  logic [31:0]  coef_merged;               // Coefficient word after a write.
  logic [17:0]  coef_reg [`NUM_COEF];      // Calibration coefficients.
  opnd_t        cx [`NUM_COEF];            // Sign-extended coefficients.
  seq_state_t   state_reg;                 // Sequencer state.
  logic [4:0]   step_reg;                  // Current arithmetic step.
  logic         sat_reg;                   // Saturation seen this run.
  opnd_t        braw_reg;                  // Latched raw bridge reading.
  opnd_t        traw_reg;                  // Latched raw temperature.
  opnd_t        dt_reg;                    // Temperature difference.
  opnd_t        k1_reg;                    // Temperature gain factor.
  opnd_t        k2_reg;                    // Offset-corrected bridge value.
  opnd_t        z_reg;                     // Bridge intermediate.
  opnd_t        zt_reg;                    // Temperature intermediate.
  opnd_t        acc_reg;                   // Scratch sum.
  opnd_t        m_reg;                     // Scratch product.
  opnd_t        br_reg;                    // Corrected bridge value.
  opnd_t        zabs;                      // Magnitude of the intermediate.
  logic         curve_s;                   // S-curve mode selected.
  alu_op_t      op;                        // Instruction of this step.
  opnd_t        alu_res;                   // ALU result.
  logic         alu_sat;                   // ALU clamped this step.
  corr_result_t result_reg;                // Delivered result.
  logic         done_reg;                  // Done pulse.

  // ================
  // Wishbone slave.

  assign aw    = {wb_adr_i[7:2], 2'b00};
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg;

  // Answer every request, mapped or not, one cycle after it appears.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
    end
  end

  // Merged write words; only the bytes named by sel change.
  assign ctrl_merged = merge({31'h0, ctrl_reg}, wb_dat_i, wb_sel_i);
  assign coef_merged = merge({14'h0, coef_reg[coef_idx(aw)]}, wb_dat_i, wb_sel_i);

  // Control register. A change in mid-run takes effect from the next step.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `CTRL_RST;
    end else if (wr_en && aw == `OFS_CTRL) begin
      ctrl_reg <= ctrl_merged[`CTRL_CURVE_BIT];
    end
  end

  // Coefficient words, one register each.
  for (genvar g = 0; g < `NUM_COEF; g++) begin : g_coef
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        coef_reg[g] <= `COEF_RST;
      end else if (wr_en && coef_hit(aw) && coef_idx(aw) == 4'(g)) begin
        coef_reg[g] <= coef_merged[17:0];  // see RULE8
      end
    end
    assign cx[g] = sx(coef_reg[g]);
  end

  // Read mux. Unmapped words and bits above the fields read as zero.
  always_comb begin
    rd_next = 32'h0;
    if (coef_hit(aw)) begin
      rd_next = {14'h0, coef_reg[coef_idx(aw)]};
    end else begin
      unique case (aw)
        `OFS_CTRL:   rd_next[`CTRL_CURVE_BIT] = ctrl_reg;
        `OFS_STATUS: begin
          rd_next[`STAT_SAT_BIT]  = result_reg.status[`STAT_SAT_BIT];
          rd_next[`STAT_BUSY_BIT] = (state_reg != ST_IDLE);
        end
        `OFS_BRIDGE: rd_next = {15'h0, result_reg.bridge};
        `OFS_TEMP:   rd_next = {15'h0, result_reg.temp};
        default:     rd_next = 32'h0;
      endcase
    end
  end

  // Read data is captured with the acknowledge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_reg <= 32'h0;
    end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      rd_reg <= rd_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;

  // ================
  // Step table.
  // One shared ALU walks the equations in order; area is traded for 23 cycles.

  assign curve_s = ctrl_reg;
  assign zabs    = z_reg[18] ? -z_reg : z_reg;

  always_comb begin
    unique case (step_reg)
      // Temperature difference and gain factor.
      5'h00: op = mk(1'b0, traw_reg, -cx[`CI_TEMP_REF], `LIM_LO, `LIM_HI, DST_DT);
      5'h01: op = mk(1'b1, cx[`CI_GAIN_DRIFT2], dt_reg, `LIM_LO, `LIM_HI, DST_M); // see RULE11
      5'h02: op = mk(1'b0, m_reg, cx[`CI_GAIN_DRIFT], `LIM_LO, `LIM_HI, DST_ACC);
      5'h03: op = mk(1'b1, dt_reg, acc_reg, `LIM_LO, `LIM_HI, DST_M);
      5'h04: op = mk(1'b0, `LIM_HALF, m_reg, `LIM_LO, `LIM_HI, DST_K1);  // see RULE11
      // Offset-corrected bridge value.
      5'h05: op = mk(1'b1, cx[`CI_OFFS_DRIFT2], dt_reg, `LIM_LO, `LIM_HI, DST_M);
      5'h06: op = mk(1'b0, m_reg, cx[`CI_OFFS_DRIFT], `LIM_LO, `LIM_HI, DST_ACC);
      5'h07: op = mk(1'b1, dt_reg, acc_reg, `LIM_LO, `LIM_HI, DST_M);
      5'h08: op = mk(1'b0, braw_reg, m_reg, `LIM_LO, `LIM_HI, DST_ACC);
      5'h09: op = mk(1'b0, cx[`CI_OFFSET_B], acc_reg, `LIM_LO, `LIM_HI, DST_K2); // see RULE11
      // Bridge intermediate.
      5'h0a: op = mk(1'b1, k1_reg, k2_reg, `LIM_LO, `LIM_HI, DST_M);  // see RULE1
      5'h0b: op = mk(1'b1, cx[`CI_GAIN_B], m_reg, `LIM_LO, `LIM_HI, DST_Z); // see RULE1
      5'h0c: begin
        if (curve_s) begin
          op = mk(1'b0, z_reg, `LIM_ZERO, `LIM_LO, `LIM_HI, DST_Z);  // see RULE1
        end else begin
          op = mk(1'b0, z_reg, `LIM_HALF, `LIM_ZERO, `LIM_HI, DST_Z);
        end
      end
      // Bridge nonlinearity; the S-curve uses the magnitude.
      5'h0d: op = mk(1'b1, cx[`CI_BRIDGE_NL], curve_s ? zabs : z_reg, `LIM_LO, `LIM_HI,
                     DST_M);  // see RULE2
      5'h0e: op = mk(1'b0, m_reg, `LIM_HALF, `LIM_LO, `LIM_HI, DST_ACC);
      5'h0f: op = mk(1'b1, z_reg, acc_reg, `LIM_LO, `LIM_HI, DST_M);
      5'h10: begin
        if (curve_s) begin
          op = mk(1'b0, m_reg, `LIM_HALF, `LIM_ZERO, `LIM_B_S, DST_BR);  // see RULE2
        end else begin
          op = mk(1'b0, m_reg, `LIM_ZERO, `LIM_ZERO, `LIM_B_P, DST_BR);
        end
      end
      // Temperature intermediate, always the parabolic form.
      5'h11: op = mk(1'b0, traw_reg, cx[`CI_OFFSET_T], `LIM_LO, `LIM_HI, DST_ACC); // see RULE5
      5'h12: op = mk(1'b1, cx[`CI_GAIN_T], acc_reg, `LIM_LO, `LIM_HI, DST_M);  // see RULE5
      5'h13: op = mk(1'b0, m_reg, `LIM_HALF, `LIM_ZERO, `LIM_HI, DST_ZT);  // see RULE4
      // Corrected temperature.
      5'h14: op = mk(1'b1, cx[`CI_TEMP_NL], zt_reg, `LIM_LO, `LIM_HI, DST_M);  // see RULE3
      5'h15: op = mk(1'b0, m_reg, `LIM_HALF, `LIM_LO, `LIM_HI, DST_ACC);  // see RULE6
      5'h16: op = mk(1'b1, zt_reg, acc_reg, `LIM_ZERO, `LIM_HI, DST_TP);  // see RULE6
      default: op = mk(1'b0, `LIM_ZERO, `LIM_ZERO, `LIM_LO, `LIM_HI, DST_M);
    endcase
  end

  // Shared arithmetic unit.
  corr_alu u_alu (
    .op_i  (op),
    .res_o (alu_res),
    .sat_o (alu_sat)
  );

  // ================
  // Sequencer.

  // A reading that arrives while busy is ignored; the source paces itself by done.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      step_reg  <= 5'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          step_reg <= 5'h00;
          if (raw_valid_i) begin
            state_reg <= ST_RUN;  // see RULE13
          end
        end
        ST_RUN: begin
          step_reg <= step_reg + 5'h01;
          if (step_reg == `LAST_STEP) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Raw readings are captured at the start and held through the run.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      braw_reg <= `LIM_ZERO;
      traw_reg <= `LIM_ZERO;
    end else if (state_reg == ST_IDLE && raw_valid_i) begin
      braw_reg <= sx(raw_bridge_i);
      traw_reg <= sx(raw_temp_i);  // see RULE7
    end
  end

  // Saturation flag gathers every clamp of the run.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sat_reg <= 1'b0;
    end else if (state_reg == ST_IDLE) begin
      sat_reg <= 1'b0;
    end else if (state_reg == ST_RUN && alu_sat) begin
      sat_reg <= 1'b1;  // see RULE9
    end
  end

  // Datapath registers, written by the step destination.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dt_reg  <= `LIM_ZERO;
      k1_reg  <= `LIM_ZERO;
      k2_reg  <= `LIM_ZERO;
      z_reg   <= `LIM_ZERO;
      zt_reg  <= `LIM_ZERO;
      acc_reg <= `LIM_ZERO;
      m_reg   <= `LIM_ZERO;
      br_reg  <= `LIM_ZERO;
    end else if (state_reg == ST_RUN) begin
      unique case (op.dst)
        DST_DT:  dt_reg  <= alu_res;
        DST_K1:  k1_reg  <= alu_res;
        DST_K2:  k2_reg  <= alu_res;
        DST_Z:   z_reg   <= alu_res;
        DST_ZT:  zt_reg  <= alu_res;
        DST_ACC: acc_reg <= alu_res;
        DST_BR:  br_reg  <= alu_res;
        default: m_reg   <= alu_res;
      endcase
    end
  end

  // Result and done pulse. The outputs are delivered even after a clamp.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_reg <= '0;
      done_reg   <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (state_reg == ST_RUN && step_reg == `LAST_STEP) begin
        result_reg.status                <= 8'h00;
        result_reg.status[`STAT_SAT_BIT] <= sat_reg | alu_sat;  // see RULE10
        result_reg.bridge                <= br_reg[16:0];
        result_reg.temp                  <= alu_res[16:0];
        done_reg                         <= 1'b1;  // see RULE13
      end
    end
  end

  assign done_o   = done_reg;
  assign result_o = result_reg;

endmodule : sensor_correction_math

// *** sim/corr_math_monitor.sv ***
// Port checker for the correction datapath, bound into its top module.
`timescale 1ns/100ps
module corr_math_monitor (
  input logic                   clk_i,       // System clock.
  input logic                   rst_i,       // Synchronous reset.
  input logic                   wb_cyc_i,    // Bus cycle.
  input logic                   wb_stb_i,    // Bus strobe.
  input logic                   wb_ack_o,    // Bus acknowledge.
  input logic                   raw_valid_i, // New reading pulse.
  input logic                   done_o,      // Result pulse.
  input corr_pkg::corr_result_t result_o     // Result word.
);
  import corr_pkg::*;
  // ================
  // Run tracking.
  logic run_reg; // High while a reading is being worked on.
  logic take;    // A reading is accepted at this edge.
  // A pulse during a run, done cycle included, is ignored.
  assign take = raw_valid_i && !run_reg;
  // Track the run from its take to its done pulse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg <= 1'b0;
    end else if (take) begin
      run_reg <= 1'b1;
    end else if (done_o) begin
      run_reg <= 1'b0;
    end
  end
  // ================
  // Properties.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  take_done_a: assert property (take |-> ##[23:25] done_o)
    else $error("no result pulse after a reading");
  done_run_a: assert property (done_o |-> run_reg)
    else $error("result pulse without a reading");
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("result pulse longer than one cycle");
  result_hold_a: assert property (!$stable(result_o) |-> done_o)
    else $error("result changed without a pulse");
  bridge_bound_a: assert property (done_o |-> result_o.bridge <= 17'h10000)
    else $error("bridge output above its bound");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("acknowledge without a request");
endmodule : corr_math_monitor

bind sensor_correction_math corr_math_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .raw_valid_i(raw_valid_i), .done_o(done_o), .result_o(result_o));

// *** sim/corr_front_model.sv ***
// Model of the auto-zero reading source and the result sink around the datapath.
`timescale 1ns/100ps
module corr_front_model (
  input  logic                   clk_i,        // System clock.
  input  logic                   rst_i,        // Synchronous reset.
  input  logic                   send_i,       // Bench asks for one reading.
  input  logic [17:0]            b_val_i,      // Bridge value to send.
  input  logic [17:0]            t_val_i,      // Temperature value to send.
  input  logic                   done_i,       // Result pulse.
  input  corr_pkg::corr_result_t result_i,     // Result word.
  output logic                   raw_valid_o,  // Reading pulse.
  output logic [17:0]            raw_bridge_o, // Raw bridge, two's complement.
  output logic [17:0]            raw_temp_o,   // Raw temperature, two's complement.
  output corr_pkg::corr_result_t cap_o,        // Last captured result.
  output int                     done_cnt_o    // Number of results seen.
);
  import corr_pkg::*;
  // ================
  // Reading source: outside its pulse the data toggles, so stale use shows.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_valid_o  <= 1'b0;
      raw_bridge_o <= 18'h00000;
      raw_temp_o   <= 18'h00000;
    end else if (send_i) begin
      raw_valid_o  <= 1'b1;
      raw_bridge_o <= b_val_i;
      raw_temp_o   <= t_val_i;
    end else begin
      raw_valid_o  <= 1'b0;
      raw_bridge_o <= ~raw_bridge_o;
      raw_temp_o   <= ~raw_temp_o;
    end
  end
  // Result sink: takes the word only in the pulse cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_o      <= '0;
      done_cnt_o <= 0;
    end else if (done_i) begin
      cap_o      <= result_i;
      done_cnt_o <= done_cnt_o + 1;
    end
  end
endmodule : corr_front_model

// *** sim/sensor_correction_math_tb.sv ***
// Self-checking bench for the sensor correction datapath.
`timescale 1ns/100ps
`include "corr_params.svh"
module sensor_correction_math_tb;
  import corr_pkg::*;
  // ================
  // Signals.
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, done_o, send, rv;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [17:0] bv, tv, rb_w, rt_w;
  corr_result_t result_o, cap;
  int dcnt, n0, miscompares, total_checks;
  logic signed [17:0] cf [11]; // Coefficients in register order.
  longint eb, et;              // Expected bridge and temperature.
  bit sat_f;                   // Expected saturation flag.
  localparam longint LO = -131072, HI = 131071;
  // ================
  // Design and partner.
  sensor_correction_math #(.RAW_W(18)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .raw_valid_i(rv), .raw_bridge_i(rb_w), .raw_temp_i(rt_w), .done_o(done_o),
    .result_o(result_o));
  corr_front_model i_front (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .b_val_i(bv),
    .t_val_i(tv), .done_i(done_o), .result_i(result_o), .raw_valid_o(rv),
    .raw_bridge_o(rb_w), .raw_temp_o(rt_w), .cap_o(cap), .done_cnt_o(dcnt));
  always #2.5 clk_i = ~clk_i;
  // ================
  // Reference arithmetic: any clamp marks the run as saturated.
  function automatic longint bnd(longint v, longint l, longint h);
    if (v < l || v > h) sat_f = 1'b1;
    return (v < l) ? l : (v > h) ? h : v;
  endfunction : bnd
  function automatic longint s(longint v);
    return bnd(v, LO, HI);
  endfunction : s
  // Expected outputs of one run, from the current coefficients.
  task automatic expect_out(input logic crv, input logic signed [17:0] rb, rt);
    longint dt, k1, k2, z, m, zt;
    sat_f = 1'b0;
    dt = s(rt - cf[7]);
    k1 = s(32768 + s((dt * s(s((cf[4] * dt) >>> 15) + cf[2])) >>> 15));
    k2 = s(cf[1] + s(rb + s((dt * s(s((cf[5] * dt) >>> 15) + cf[3])) >>> 15)));
    if (crv) begin
      z = s((cf[0] * s((k1 * k2) >>> 15)) >>> 15);
      m = s(s((cf[6] * (z < 0 ? -z : z)) >>> 15) + 32768);
      eb = bnd(s((z * m) >>> 15) + 32768, 0, 65536);
    end else begin
      z = bnd(s((cf[0] * s((k1 * k2) >>> 15)) >>> 15) + 32768, 0, HI);
      eb = bnd((z * s(s((cf[6] * z) >>> 15) + 32768)) >>> 15, 0, 65535);
    end
    zt = bnd(s((cf[8] * s(rt + cf[9])) >>> 15) + 32768, 0, HI);
    et = bnd((zt * s(s((cf[10] * zt) >>> 15) + 32768)) >>> 15, 0, HI);
  endtask : expect_out
  // ================
  // Compare tasks and closing report.
  task automatic cmp_word(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_res(input corr_result_t got);
    total_checks++;
    if ({got.status[0], got.bridge, got.temp} !== {sat_f, eb[16:0], et[16:0]}) begin
      miscompares++;
      $display("wrong value at %0t: result %h", $time, got);
    end
  endtask : cmp_res
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // Stall guard: a wait that runs out ends the run.
  task automatic timed_out(input int n);
    if (n >= 60) begin
      miscompares++;
      $display("wrong value at %0t: no answer", $time);
      close_out();
    end
  endtask : timed_out
  // ================
  // Bus and reading tasks: request held until ack is sampled high.
  task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (wb_ack_o !== 1'b1 && n < 60);
    @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    timed_out(n);
  endtask : wb_io
  task automatic wb_chk(input logic [7:0] a, input logic [31:0] exp);
    wb_io(1'b0, a, 32'h0);
    cmp_word(q, exp, "register");
  endtask : wb_chk
  task automatic send_rd(input logic [17:0] b, t);
    @(posedge clk_i);
    bv   <= b;
    tv   <= t;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
  endtask : send_rd
  // Wait for the result pulse, then let the captured word land.
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (done_o !== 1'b1 && n < 60);
    timed_out(n);
    @(posedge clk_i);
    #1;
  endtask : wait_done
  // One full run: load registers, send a reading, check all outputs.
  task automatic run_case(input logic crv, input logic [17:0] rb, rt, input string nm);
    wb_io(1'b1, `OFS_CTRL, {31'h0, crv});
    for (int i = 0; i < `NUM_COEF; i++) wb_io(1'b1, `OFS_COEF_BASE + 8'(4 * i), {14'h0, cf[i]});
    wb_chk(`OFS_COEF_BASE + 8'h18, {14'h0, cf[6]});
    send_rd(rb, rt);
    wait_done();
    expect_out(crv, rb, rt);
    cmp_res(cap);
    wb_chk(`OFS_BRIDGE, {15'h0, eb[16:0]});
    wb_chk(`OFS_TEMP, {15'h0, et[16:0]});
    wb_chk(`OFS_STATUS, {31'h0, sat_f});
    $display("test %s ended", nm);
  endtask : run_case
  // ================
  // Main sequence.
  initial begin
    {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, send, miscompares, total_checks} = '0;
    {wb_adr_i, wb_dat_i, bv, tv} = '0;
    wb_sel_i = 4'hf;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 'h3c; a += 4) wb_chk(8'(a), 32'h0);
    wb_io(1'b1, `OFS_CTRL, 32'hffffffff);
    wb_chk(`OFS_CTRL, 32'h1);
    wb_io(1'b1, `OFS_STATUS, 32'hffffffff);
    wb_chk(`OFS_STATUS, 32'h0);
    wb_io(1'b1, 8'h3c, 32'hffffffff);
    wb_chk(8'h3c, 32'h0);
    $display("test registers ended");
    cf = '{18'h08000, 0, 0, 0, 0, 0, 18'h00400, 0, 18'h08000, 0, 18'h00200};
    run_case(1'b0, 18'h01000, 18'h00100, "parabolic");
    cf[6] = 18'h3fc00;
    run_case(1'b1, 18'h3f000, 18'h00100, "s_negative");
    cf = '{18'h10000, 18'h1ffff, 18'h01000, 18'h00800, 18'h00200, 18'h00200,
           18'h00400, 18'h00100, 18'h08000, 18'h00050, 18'h00200};
    run_case(1'b1, 18'h1ffff, 18'h02000, "s_saturate");
    cf[0] = 18'h20001;
    cf[9] = 18'h20001;
    run_case(1'b0, 18'h1ffff, 18'h20001, "temp_low");
    send_rd(18'h01000, 18'h00100);
    wb_io(1'b0, `OFS_STATUS, 32'h0);
    cmp_word(q & 32'h2, 32'h2, "busy");
    send_rd(18'h3f000, 18'h3ff00);
    wait_done();
    expect_out(1'b0, 18'h01000, 18'h00100);
    cmp_res(cap);
    n0 = dcnt;
    repeat (40) @(posedge clk_i);
    cmp_word(32'(dcnt), 32'(n0), "extra result");
    $display("test busy ended");
    close_out();
  end
endmodule : sensor_correction_math_tb
